// ===== psfr_top.sv
// fault protection and open-drain fault reporting of a mono power stage
// Operation
// - both flags low report a high-temperature error, or a high-current error or undervoltage at the warning temperature.
// - at the warning temperature the warning flag goes low, shutdown stays high.
// - shutdown low with warning high reports undervoltage lockout or a high-current error.
// - both flags high report normal operation with nothing active but current limiting.
// - an overcurrent first limits the current instead of shutting down.
// - a persisting overcurrent latches a shutdown with the stage in high impedance.
// - a further rise in temperature shuts the stage down and pulls both flags low.
// - both flags are open-drain, pulled low when asserted and released otherwise.
`timescale 1ns/10ps
`default_nettype none
module psfr_top
    import psfr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic overcurrent_sense,
    input wire logic temp_warn_sense,
    input wire logic temp_crit_sense,
    input wire logic undervolt_sense,
    input wire logic overtemp_warn_n_in,
    output logic overtemp_warn_n_out,
    output logic overtemp_warn_n_oe_n,
    input wire logic shutdown_flag_n_in,
    output logic shutdown_flag_n_out,
    output logic shutdown_flag_n_oe_n,
    output logic overcurrent_guard,
    output logic stage_hiz,
    output logic shared_warn,
    output logic shared_shutdown
);
    psfr_fault_if flt_if ();

    logic [FLT_W-1:0] raw;
    logic oc_f;
    logic twarn_f;
    logic tcrit_f;
    logic uv_f;
    psfr_oc_state_e oc_state_reg;
    psfr_oc_state_e oc_state_next;
    logic [OC_CNT_W-1:0] oc_cnt_reg;
    logic [OC_CNT_W-1:0] oc_cnt_next;
    logic warn_assert;
    logic shut_assert;

    // line readback lets the controller-side view of the wired-OR be observed
    assign raw = {~shutdown_flag_n_in, ~overtemp_warn_n_in, undervolt_sense,
                  temp_crit_sense, temp_warn_sense, overcurrent_sense};

    psfr_in_filter u_filter
    (
        .clk_sys(clk_sys),
        .reset(reset),
        .raw(raw),
        .flt(flt_if.src)
    );

    assign oc_f = flt_if.level[FLT_OVERCURRENT];
    assign twarn_f = flt_if.level[FLT_TEMP_WARN];
    assign tcrit_f = flt_if.level[FLT_TEMP_CRIT];
    assign uv_f = flt_if.level[FLT_UNDERVOLT];

    always_comb
    begin
        oc_state_next = oc_state_reg;
        oc_cnt_next = oc_cnt_reg;
        unique case (oc_state_reg)
            PSFR_OC_IDLE:
            begin
                oc_cnt_next = OC_CNT_RESET;
                if (oc_f)
                    oc_state_next = PSFR_OC_LIMIT;
            end
            PSFR_OC_LIMIT:
            begin
                // a transient that ends inside the window is forgiven
                if (!oc_f)
                    oc_state_next = PSFR_OC_IDLE;
                else if (oc_cnt_reg == OC_CNT_LAST)
                    oc_state_next = PSFR_OC_LATCH;
                else
                    oc_cnt_next = oc_cnt_reg + 12'h001;
            end
            PSFR_OC_LATCH:
                oc_state_next = PSFR_OC_LATCH;
            default:
                oc_state_next = PSFR_OC_LATCH;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            oc_state_reg <= PSFR_OC_IDLE;
            oc_cnt_reg <= OC_CNT_RESET;
        end
        else
        begin
            oc_state_reg <= oc_state_next;
            oc_cnt_reg <= oc_cnt_next;
        end
    end

    // over-temperature shutdown holds only while the critical level lasts
    assign warn_assert = twarn_f | tcrit_f;
    assign shut_assert = tcrit_f | uv_f | (oc_state_next == PSFR_OC_LATCH);

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            overtemp_warn_n_oe_n <= OE_N_RELEASE;
            shutdown_flag_n_oe_n <= OE_N_RELEASE;
        end
        else
        begin
            overtemp_warn_n_oe_n <= ~warn_assert;
            shutdown_flag_n_oe_n <= ~shut_assert;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            overtemp_warn_n_out <= FLAG_DRIVE_LEVEL;
            shutdown_flag_n_out <= FLAG_DRIVE_LEVEL;
        end
        else
        begin
            overtemp_warn_n_out <= FLAG_DRIVE_LEVEL;
            shutdown_flag_n_out <= FLAG_DRIVE_LEVEL;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            overcurrent_guard <= 1'b0;
            stage_hiz <= 1'b0;
        end
        else
        begin
            overcurrent_guard <= (oc_state_next == PSFR_OC_LIMIT);
            stage_hiz <= shut_assert;
        end
    end

    // filtered levels of the shared lines, asserted high
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            shared_warn <= 1'b0;
            shared_shutdown <= 1'b0;
        end
        else
        begin
            shared_warn <= flt_if.level[FLT_LINE_WARN];
            shared_shutdown <= flt_if.level[FLT_LINE_SHUT];
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence s_overload_held;
        oc_state_reg == PSFR_OC_LIMIT && oc_cnt_reg == OC_CNT_LAST && oc_f;
    endsequence

    sequence s_latched_out;
        stage_hiz && !shutdown_flag_n_oe_n && !overcurrent_guard;
    endsequence

    warn_only_a: assert property (twarn_f && !tcrit_f && !uv_f && oc_state_reg == PSFR_OC_IDLE
        && !oc_f |=> !overtemp_warn_n_oe_n && shutdown_flag_n_oe_n)
        else $error("warning-only code not shown");
    both_low_a: assert property (tcrit_f |=> !overtemp_warn_n_oe_n && !shutdown_flag_n_oe_n
        && stage_hiz)
        else $error("critical temperature did not pull both flags low");
    uvlo_code_a: assert property (uv_f && !twarn_f && !tcrit_f |=> overtemp_warn_n_oe_n
        && !shutdown_flag_n_oe_n)
        else $error("undervoltage code wrong");
    normal_code_a: assert property (!twarn_f && !tcrit_f && !uv_f && oc_state_reg != PSFR_OC_LATCH
        && !(oc_state_reg == PSFR_OC_LIMIT && oc_f && oc_cnt_reg == OC_CNT_LAST)
        |=> overtemp_warn_n_oe_n && shutdown_flag_n_oe_n)
        else $error("flags not released in normal operation");
    limit_first_a: assert property (oc_state_reg == PSFR_OC_IDLE && oc_f && !tcrit_f && !uv_f
        |=> overcurrent_guard && !stage_hiz)
        else $error("overcurrent did not limit first");
    latch_after_a: assert property (s_overload_held |=> s_latched_out)
        else $error("persisting overload did not latch");
    latch_holds_a: assert property (oc_state_reg == PSFR_OC_LATCH |=> s_latched_out [*3])
        else $error("latched shutdown released");
    error_code_a: assert property (oc_state_reg == PSFR_OC_LATCH && twarn_f
        |=> !overtemp_warn_n_oe_n && !shutdown_flag_n_oe_n)
        else $error("combined error code not shown");
    drive_low_a: assert property ((!overtemp_warn_n_oe_n || !shutdown_flag_n_oe_n)
        |-> overtemp_warn_n_out == FLAG_DRIVE_LEVEL
        && shutdown_flag_n_out == FLAG_DRIVE_LEVEL)
        else $error("open-drain pin driven high");
endmodule : psfr_top
`default_nettype wire

// ===== psfr_pkg.sv
// constants and types shared by the power stage fault reporting block
package psfr_pkg;
    localparam int CLK_PERIOD_NS = 8;
    // time an overload may be current-limited before the latched shutdown
    localparam int OC_PERSIST_NS = 1000;
    localparam int OC_PERSIST_CYC = (OC_PERSIST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OC_CNT_W = 12;
    localparam logic [OC_CNT_W-1:0] OC_CNT_LAST = OC_CNT_W'(OC_PERSIST_CYC - 1);
    localparam logic [OC_CNT_W-1:0] OC_CNT_RESET = 12'h000;
    // qualified input bit positions
    localparam int FLT_OVERCURRENT = 0;
    localparam int FLT_TEMP_WARN = 1;
    localparam int FLT_TEMP_CRIT = 2;
    localparam int FLT_UNDERVOLT = 3;
    localparam int FLT_LINE_WARN = 4;
    localparam int FLT_LINE_SHUT = 5;
    localparam int FLT_W = 6;
    // all bits idle after reset, so the shared lines show no false assertion on release
    localparam logic [FLT_W-1:0] FLT_RESET = 6'h00;
    // open-drain pins: the driven value is always low
    localparam logic FLAG_DRIVE_LEVEL = 1'b0;
    localparam logic OE_N_RELEASE = 1'b1;
    typedef enum logic [1:0]
    {
        PSFR_OC_IDLE = 2'b00,
        PSFR_OC_LIMIT = 2'b01,
        PSFR_OC_LATCH = 2'b11
    } psfr_oc_state_e;
endpackage : psfr_pkg

// ===== psfr_fault_if.sv
// carrier for the qualified fault levels between the input filter and the top
`timescale 1ns/10ps
`default_nettype none
interface psfr_fault_if;
    import psfr_pkg::*;
    logic [FLT_W-1:0] level;
    modport src (output level);
    modport dst (input level);
endinterface : psfr_fault_if
`default_nettype wire

// ===== psfr_in_filter.sv
// three-stage synchroniser and agreement filter for asynchronous inputs
`timescale 1ns/10ps
`default_nettype none
module psfr_in_filter
    import psfr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [FLT_W-1:0] raw,
    psfr_fault_if.src flt
);
    logic [FLT_W-1:0] s1_reg;
    logic [FLT_W-1:0] s2_reg;
    logic [FLT_W-1:0] s3_reg;
    logic [FLT_W-1:0] q_reg;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            s1_reg <= FLT_RESET;
            s2_reg <= FLT_RESET;
            s3_reg <= FLT_RESET;
        end
        else
        begin
            s1_reg <= raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // a change counts only once stages two and three agree; s1 feeds s2 alone
    for (genvar i = 0; i < FLT_W; i++)
    begin : g_bit
        always_ff @(posedge clk_sys)
        begin
            if (reset)
                q_reg[i] <= FLT_RESET[i];
            else if (s2_reg[i] == s3_reg[i])
                q_reg[i] <= s3_reg[i];
        end
    end

    assign flt.level = q_reg;
endmodule : psfr_in_filter
`default_nettype wire

// ===== psfr_partner.sv
// model of a peer stage on the shared flag lines and of the controller that decodes them
`timescale 1ns/10ps
`default_nettype none
module psfr_partner
(
    input wire logic clk_sys,
    input wire logic dut_warn_oe_n,
    input wire logic dut_shut_oe_n,
    input wire logic peer_warn,
    input wire logic peer_shut,
    output logic warn_line,
    output logic shut_line,
    output logic [1:0] cond_reg
);
    logic [1:0] sync_reg;
    // pull-up on each line: high unless some stage pulls it low
    assign warn_line = ~(~dut_warn_oe_n | peer_warn);
    assign shut_line = ~(~dut_shut_oe_n | peer_shut);
    // the lines move asynchronously to the controller, so two flops before decoding
    always_ff @(posedge clk_sys)
    begin
        sync_reg <= {warn_line, shut_line};
        cond_reg <= sync_reg;
    end
endmodule : psfr_partner
`default_nettype wire

// ===== testbench.sv
// self-checking bench for the power stage fault reporting block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import psfr_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic oc = 1'b0, tw = 1'b0, tc = 1'b0, uv = 1'b0, pw = 1'b0, ps = 1'b0;
    logic warn_line, shut_line, w_out, w_oe_n, s_out, s_oe_n, guard, hiz, sh_w, sh_s;
    logic lat = 1'b0;
    logic [1:0] cond;
    int num_errors = 0;
    int n_tests = 0;
    int oc_run = 0;
    int seed = 32'h06b2_a533;

    always #4 clk_sys = ~clk_sys;

    psfr_top i_dut (.clk_sys(clk_sys), .reset(reset), .overcurrent_sense(oc),
        .temp_warn_sense(tw), .temp_crit_sense(tc), .undervolt_sense(uv),
        .overtemp_warn_n_in(warn_line), .overtemp_warn_n_out(w_out),
        .overtemp_warn_n_oe_n(w_oe_n), .shutdown_flag_n_in(shut_line),
        .shutdown_flag_n_out(s_out), .shutdown_flag_n_oe_n(s_oe_n),
        .overcurrent_guard(guard), .stage_hiz(hiz), .shared_warn(sh_w),
        .shared_shutdown(sh_s));

    psfr_partner i_ctrl (.clk_sys(clk_sys), .dut_warn_oe_n(w_oe_n), .dut_shut_oe_n(s_oe_n),
        .peer_warn(pw), .peer_shut(ps), .warn_line(warn_line), .shut_line(shut_line),
        .cond_reg(cond));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up

    task automatic do_reset;
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        chk({4'h0, w_oe_n, s_oe_n, guard, hiz}, 8'h0c);
        @(posedge clk_sys);
        reset <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        chk({6'h00, sh_w, sh_s}, 8'h00);
        lat = 1'b0;
        oc_run = 0;
    endtask : do_reset

    // v = {oc, tw, tc, uv, peer warn, peer shutdown}; n cycles to settle
    task automatic step(input logic [5:0] v, input int n);
        logic [7:0] exp;
        @(posedge clk_sys);
        {oc, tw, tc, uv, pw, ps} <= v;
        oc_run = v[5] ? oc_run + n : 0;
        // the latch is due near 130 cycles; 120 and 140 bracket it with margin
        if (oc_run >= 140)
            lat = 1'b1;
        repeat (n) @(posedge clk_sys);
        #1;
        exp = {2'b00, ~(v[4] | v[3]), ~(v[3] | v[2] | lat), v[5] & ~lat,
            v[3] | v[2] | lat, v[4] | v[3] | v[1], v[3] | v[2] | lat | v[0]};
        chk({w_out, s_out, w_oe_n, s_oe_n, guard, hiz, sh_w, sh_s}, exp);
        chk({6'h00, cond}, {6'h00, ~exp[1], ~exp[0]});
    endtask : step

    initial
    begin
        repeat (5000) @(posedge clk_sys);
        num_errors++;
        wrap_up();
    end

    initial
    begin
        do_reset();
        step(6'h00, 10);
        step(6'h10, 10);
        step(6'h08, 10);
        step(6'h04, 10);
        step(6'h02, 10);
        step(6'h01, 10);
        $display("test flag decoding done");
        step(6'h20, 10);
        step(6'h00, 10);
        step(6'h20, 120);
        step(6'h20, 20);
        step(6'h10, 10);
        $display("test overcurrent done");
        do_reset();
        step(6'h00, 10);
        repeat (20) step(6'($random(seed)) & 6'h1f, 10);
        $display("test random flags done");
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
